// *** audio_route_consts.svh ***
/*
  register offsets, field positions and reset values of the audio port
  routing and status register slice.
  assumes: included by bare name from any file that needs the map.
*/
`ifndef AUDIO_ROUTE_CONSTS_SVH
`define AUDIO_ROUTE_CONSTS_SVH

`define OFS_AUDIO_PORT_ROUTING 8'h21
`define OFS_BUS_GENERAL_CALL_CTRL 8'h22
`define OFS_RESERVED_SLOT_A 8'h23
`define OFS_RECORD_STATUS 8'h24
`define OFS_PLAYBACK_POWER_STATUS 8'h25
`define OFS_PLAYBACK_GAIN_STATUS 8'h26
`define OFS_OVERFLOW_STATUS 8'h27
`define OFS_RESERVED_FIRST 8'h28
`define OFS_RESERVED_LAST 8'h2B

`define RST_AUDIO_PORT_ROUTING 8'h00
`define RST_BUS_GENERAL_CALL_CTRL 8'h00

`define POS_PRI_BCLK_SEL 7
`define POS_SEC_BCLK_SEL 6
`define POS_PRI_WCLK_HI 5
`define POS_PRI_WCLK_LO 4
`define POS_SEC_WCLK_HI 3
`define POS_SEC_WCLK_LO 2
`define POS_PRI_DOUT_SEL 1
`define POS_SEC_DOUT_SEL 0
`define POS_GENERAL_CALL_EN 5

`define POS_REC_GAIN_OK 7
`define POS_REC_POWERED 6
`define POS_AGC_SAT 5

`define POS_LEFT_CONV_PWR 7
`define POS_LEFT_HP_PWR 5
`define POS_LEFT_SPK_PWR 4
`define POS_RIGHT_CONV_PWR 3
`define POS_RIGHT_HP_PWR 1
`define POS_RIGHT_SPK_PWR 0

`define POS_LEFT_GAIN_OK 4
`define POS_RIGHT_GAIN_OK 0

`define POS_OVF_LEFT_PLAY 7
`define POS_OVF_RIGHT_PLAY 6
`define POS_OVF_PLAY_SHIFT 5
`define POS_OVF_REC_CONV 3
`define POS_OVF_REC_SHIFT 1

`define NUM_STICKY 6

`endif

// *** audio_route_pkg.sv ***
/*
  types shared by the routing and status register slice.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package audio_route_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef enum logic [1:0] {
    PRI_WCLK_PLAY,
    PRI_WCLK_REC,
    PRI_WCLK_SEC,
    PRI_WCLK_RSVD
  } pri_wclk_sel_t;
  typedef enum logic [1:0] {
    SEC_WCLK_PRI,
    SEC_WCLK_PLAY,
    SEC_WCLK_REC,
    SEC_WCLK_RSVD
  } sec_wclk_sel_t;
endpackage

// *** sticky_flag_bank.sv ***
/*
  bank of sticky event flags set by pulses and cleared by a read strobe.
  assumes: set pulses and the read strobe are on i_clk; a set that meets the
  clear in the same cycle survives.
*/
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int N = 6
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [N-1:0] i_set,
  input wire logic [N-1:0] i_clr,
  output logic [N-1:0] o_flags
);
  // refuse an empty bank at elaboration rather than build no logic at all
  if (N < 1) begin : gen_bad_n
    $error("sticky_flag_bank needs at least one flag");
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_flag
      logic flag_q;
      always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
          flag_q <= 1'b0;
        end else if (i_set[g]) begin
          flag_q <= 1'b1; // R17
        end else if (i_clr[g]) begin
          flag_q <= 1'b0; // R11
        end
      end
      assign o_flags[g] = flag_q;

      property p_set_wins;
        @(posedge i_clk) disable iff (i_sys_rst)
          i_set[g] |=> flag_q;
      endproperty
      a_set_wins: assert property (p_set_wins) else $error("flag set lost"); // R17

      property p_read_clears;
        @(posedge i_clk) disable iff (i_sys_rst)
          (i_clr[g] && !i_set[g]) |=> !flag_q;
      endproperty
      a_read_clears: assert property (p_read_clears) else $error("flag not cleared by read"); // R11
    end
  endgenerate
endmodule

// *** audio_route_regs.sv ***
/*
  audio port routing control, general-call enable and status/overflow
  registers of the codec control slice.
  assumes: register accesses arrive as single-cycle read/write strobes on
  i_clk from the control-bus slave; serial audio pins and internal codec
  clocks belong to the link domain i_link_clk; status sources arrive from
  other clocks and are synchronised here; event sources are level toggles.
*/
// Behaviour
// R01 - primary bit clock: internal when routing D7 low, secondary input when high
// R02 - secondary bit clock: primary bit clock when D6 low, internal when high
// R03 - D5-D4 picks primary word clock: playback, record, secondary; 11 reserved
// R04 - D3-D2 picks secondary word clock: primary, playback, record; 11 reserved
// R05 - primary data out: interface data when D1 low, secondary input when high
// R06 - secondary data out: primary input when D0 low, interface data when high
// R07 - general-call address accepted only while bus-condition D5 is set
// R08 - record status D7 high only while input gain amp reaches programmed gain
// R09 - record status D6 shows record converter power state
// R10 - record status D5 sticky, set when auto gain control saturates
// R11 - sticky flags are read-only and clear when read
// R12 - playback power status bits show converter and driver power, 1 powered
// R13 - playback gain status D4 left, D0 right show gain reached
// R14 - overflow D7, D6, D5 sticky: left, right playback, playback shifter
// R15 - overflow D3, D1 sticky: record converter, record shifter
// R16 - software leaves gain-status D7-D5 unwritten, reserved bits written zero
// R17 - status sampled on register clock; event during read kept for next read
`timescale 1ns/1ps
`include "audio_route_consts.svh"
module audio_route_regs (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_clk,
  input wire logic i_link_rst,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire audio_route_pkg::reg_byte_t i_reg_wdata,
  output audio_route_pkg::reg_byte_t o_reg_rdata,
  output logic o_general_call_en,
  input wire logic i_int_bclk,
  input wire logic i_play_rate_clk,
  input wire logic i_rec_rate_clk,
  input wire logic i_iface_dout,
  input wire logic i_pri_bclk,
  input wire logic i_pri_wclk,
  input wire logic i_pri_din,
  input wire logic i_sec_bclk,
  input wire logic i_sec_wclk,
  input wire logic i_sec_din,
  output logic o_pri_bclk,
  output logic o_pri_wclk,
  output logic o_pri_dout,
  output logic o_sec_bclk,
  output logic o_sec_wclk,
  output logic o_sec_dout,
  input wire logic i_rec_gain_ok,
  input wire logic i_rec_powered,
  input wire logic [5:0] i_play_power,
  input wire logic i_left_gain_ok,
  input wire logic i_right_gain_ok,
  input wire logic [`NUM_STICKY-1:0] i_event_tgl
);
  import audio_route_pkg::*;

  localparam int NS = `NUM_STICKY;
  localparam int NLVL = 10;

  // control registers, i_clk domain
  reg_byte_t routing_q;
  reg_byte_t gcall_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      routing_q <= `RST_AUDIO_PORT_ROUTING;
    end else if (i_reg_wr && i_reg_addr == `OFS_AUDIO_PORT_ROUTING) begin
      routing_q <= i_reg_wdata;
    end
  end

  // only the enable bit is kept; reserved bits read as zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      gcall_q <= `RST_BUS_GENERAL_CALL_CTRL;
    end else if (i_reg_wr && i_reg_addr == `OFS_BUS_GENERAL_CALL_CTRL) begin
      gcall_q <= 8'h00;
      gcall_q[`POS_GENERAL_CALL_EN] <= i_reg_wdata[`POS_GENERAL_CALL_EN];
    end
  end

  assign o_general_call_en = gcall_q[`POS_GENERAL_CALL_EN]; // R07

  // a routing write toggles a flag; the link side copies the whole byte only once
  // the toggle has passed two flops, so select bits never change one by one.
  // limitation: routing writes must be some four link cycles apart
  logic route_tgl_q;
  logic [2:0] tgl_sync_q;
  logic [7:0] route_s2_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      route_tgl_q <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == `OFS_AUDIO_PORT_ROUTING) begin
      route_tgl_q <= ~route_tgl_q;
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (i_link_rst) begin
      tgl_sync_q <= 3'h0;
      route_s2_q <= 8'h00;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], route_tgl_q};
      if (tgl_sync_q[2] ^ tgl_sync_q[1]) begin
        route_s2_q <= routing_q;
      end
    end
  end

  pri_wclk_sel_t pri_wsel;
  sec_wclk_sel_t sec_wsel;
  assign pri_wsel = pri_wclk_sel_t'(route_s2_q[`POS_PRI_WCLK_HI:`POS_PRI_WCLK_LO]);
  assign sec_wsel = sec_wclk_sel_t'(route_s2_q[`POS_SEC_WCLK_HI:`POS_SEC_WCLK_LO]);

  // clocks and data are muxed combinationally: a register stage would cost a
  // link cycle of skew between bit clock and data on the forwarded path
  always_comb begin
    o_pri_bclk = route_s2_q[`POS_PRI_BCLK_SEL] ? i_sec_bclk : i_int_bclk; // R01
    o_sec_bclk = route_s2_q[`POS_SEC_BCLK_SEL] ? i_int_bclk : i_pri_bclk; // R02
    o_pri_dout = route_s2_q[`POS_PRI_DOUT_SEL] ? i_sec_din : i_iface_dout; // R05
    o_sec_dout = route_s2_q[`POS_SEC_DOUT_SEL] ? i_iface_dout : i_pri_din; // R06
  end

  // reserved code drives low rather than an undefined clock
  always_comb begin
    case (pri_wsel) // R03
      PRI_WCLK_PLAY: o_pri_wclk = i_play_rate_clk;
      PRI_WCLK_REC: o_pri_wclk = i_rec_rate_clk;
      PRI_WCLK_SEC: o_pri_wclk = i_sec_wclk;
      default: o_pri_wclk = 1'b0;
    endcase
  end

  always_comb begin
    case (sec_wsel) // R04
      SEC_WCLK_PRI: o_sec_wclk = i_pri_wclk;
      SEC_WCLK_PLAY: o_sec_wclk = i_play_rate_clk;
      SEC_WCLK_REC: o_sec_wclk = i_rec_rate_clk;
      default: o_sec_wclk = 1'b0;
    endcase
  end

  // status levels: two-flop synchronisers into i_clk
  logic [NLVL-1:0] lvl_raw;
  logic [NLVL-1:0] lvl_s1_q;
  logic [NLVL-1:0] lvl_q;
  assign lvl_raw = {i_rec_gain_ok, i_rec_powered, i_play_power, i_left_gain_ok, i_right_gain_ok};

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lvl_s1_q <= '0;
      lvl_q <= '0;
    end else begin
      lvl_s1_q <= lvl_raw;
      lvl_q <= lvl_s1_q; // R17
    end
  end

  logic rec_gain_ok_s;
  logic rec_powered_s;
  logic [5:0] play_power_s;
  logic left_gain_ok_s;
  logic right_gain_ok_s;
  assign rec_gain_ok_s = lvl_q[9];
  assign rec_powered_s = lvl_q[8];
  assign play_power_s = lvl_q[7:2];
  assign left_gain_ok_s = lvl_q[1];
  assign right_gain_ok_s = lvl_q[0];

  // events arrive as toggles; each change is one occurrence
  logic [NS-1:0] ev_s1_q;
  logic [NS-1:0] ev_s2_q;
  logic [NS-1:0] ev_s3_q;
  logic [NS-1:0] ev_pulse;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ev_s1_q <= '0;
      ev_s2_q <= '0;
      ev_s3_q <= '0;
    end else begin
      ev_s1_q <= i_event_tgl;
      ev_s2_q <= ev_s1_q;
      ev_s3_q <= ev_s2_q;
    end
  end

  assign ev_pulse = ev_s2_q ^ ev_s3_q;

  // flag order: 5 agc sat, 4 left ovf, 3 right ovf, 2 play shift, 1 rec conv, 0 rec shift
  logic [NS-1:0] flag_clr;
  logic [NS-1:0] flags;
  logic rd_rec;
  logic rd_ovf;
  assign rd_rec = i_reg_rd && i_reg_addr == `OFS_RECORD_STATUS;
  assign rd_ovf = i_reg_rd && i_reg_addr == `OFS_OVERFLOW_STATUS;
  assign flag_clr = {rd_rec, {(NS - 1){rd_ovf}}}; // R11

  sticky_flag_bank #(
    .N(NS)
  ) u_flags (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_set(ev_pulse),
    .i_clr(flag_clr),
    .o_flags(flags)
  );

  // read view of each status register
  reg_byte_t rec_view;
  reg_byte_t pwr_view;
  reg_byte_t gain_view;
  reg_byte_t ovf_view;

  always_comb begin
    rec_view = 8'h00;
    rec_view[`POS_REC_GAIN_OK] = rec_gain_ok_s; // R08
    rec_view[`POS_REC_POWERED] = rec_powered_s; // R09
    rec_view[`POS_AGC_SAT] = flags[5]; // R10
  end

  always_comb begin
    pwr_view = 8'h00;
    pwr_view[`POS_LEFT_CONV_PWR] = play_power_s[5]; // R12
    pwr_view[`POS_LEFT_HP_PWR] = play_power_s[4];
    pwr_view[`POS_LEFT_SPK_PWR] = play_power_s[3];
    pwr_view[`POS_RIGHT_CONV_PWR] = play_power_s[2];
    pwr_view[`POS_RIGHT_HP_PWR] = play_power_s[1];
    pwr_view[`POS_RIGHT_SPK_PWR] = play_power_s[0];
  end

  // writes to status registers are dropped, so reserved bits cannot be disturbed
  always_comb begin
    gain_view = 8'h00; // R16
    gain_view[`POS_LEFT_GAIN_OK] = left_gain_ok_s; // R13
    gain_view[`POS_RIGHT_GAIN_OK] = right_gain_ok_s;
  end

  always_comb begin
    ovf_view = 8'h00;
    ovf_view[`POS_OVF_LEFT_PLAY] = flags[4]; // R14
    ovf_view[`POS_OVF_RIGHT_PLAY] = flags[3];
    ovf_view[`POS_OVF_PLAY_SHIFT] = flags[2];
    ovf_view[`POS_OVF_REC_CONV] = flags[1]; // R15
    ovf_view[`POS_OVF_REC_SHIFT] = flags[0];
  end

  // read data registered on the strobe cycle; unmapped addresses return zero
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      if (i_reg_addr == `OFS_AUDIO_PORT_ROUTING) begin
        o_reg_rdata <= routing_q;
      end else if (i_reg_addr == `OFS_BUS_GENERAL_CALL_CTRL) begin
        o_reg_rdata <= gcall_q;
      end else if (i_reg_addr == `OFS_RECORD_STATUS) begin
        o_reg_rdata <= rec_view;
      end else if (i_reg_addr == `OFS_PLAYBACK_POWER_STATUS) begin
        o_reg_rdata <= pwr_view;
      end else if (i_reg_addr == `OFS_PLAYBACK_GAIN_STATUS) begin
        o_reg_rdata <= gain_view;
      end else if (i_reg_addr == `OFS_OVERFLOW_STATUS) begin
        o_reg_rdata <= ovf_view;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  property p_pri_bclk_route;
    @(posedge i_link_clk) disable iff (i_link_rst)
      o_pri_bclk == (route_s2_q[`POS_PRI_BCLK_SEL] ? i_sec_bclk : i_int_bclk);
  endproperty
  a_pri_bclk_route: assert property (p_pri_bclk_route) else $error("primary bclk misrouted"); // R01

  property p_sec_bclk_route;
    @(posedge i_link_clk) disable iff (i_link_rst)
      !route_s2_q[`POS_SEC_BCLK_SEL] |-> o_sec_bclk == i_pri_bclk;
  endproperty
  a_sec_bclk_route: assert property (p_sec_bclk_route) else $error("secondary bclk misrouted"); // R02

  property p_pri_wclk_sec;
    @(posedge i_link_clk) disable iff (i_link_rst)
      route_s2_q[5:4] == 2'h2 |-> o_pri_wclk == i_sec_wclk;
  endproperty
  a_pri_wclk_sec: assert property (p_pri_wclk_sec) else $error("primary wclk misrouted"); // R03

  property p_sec_wclk_play;
    @(posedge i_link_clk) disable iff (i_link_rst)
      route_s2_q[3:2] == 2'h1 |-> o_sec_wclk == i_play_rate_clk;
  endproperty
  a_sec_wclk_play: assert property (p_sec_wclk_play) else $error("secondary wclk misrouted"); // R04

  property p_pri_dout_route;
    @(posedge i_link_clk) disable iff (i_link_rst)
      route_s2_q[`POS_PRI_DOUT_SEL] |-> o_pri_dout == i_sec_din;
  endproperty
  a_pri_dout_route: assert property (p_pri_dout_route) else $error("primary dout misrouted"); // R05

  property p_sec_dout_route;
    @(posedge i_link_clk) disable iff (i_link_rst)
      route_s2_q[`POS_SEC_DOUT_SEL] |-> o_sec_dout == i_iface_dout;
  endproperty
  a_sec_dout_route: assert property (p_sec_dout_route) else $error("secondary dout misrouted"); // R06

  property p_gcall_write;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_wr && i_reg_addr == `OFS_BUS_GENERAL_CALL_CTRL) |=> o_general_call_en == $past(i_reg_wdata[5]);
  endproperty
  a_gcall_write: assert property (p_gcall_write) else $error("general-call enable not written"); // R07

  property p_rec_gain_read;
    @(posedge i_clk) disable iff (i_sys_rst)
      rd_rec |=> o_reg_rdata[7] == $past(rec_gain_ok_s) && o_reg_rdata[6] == $past(rec_powered_s);
  endproperty
  a_rec_gain_read: assert property (p_rec_gain_read) else $error("record status wrong"); // R08

  property p_ovf_read_clear;
    @(posedge i_clk) disable iff (i_sys_rst)
      (rd_ovf && ev_pulse[4:0] == 5'h00) |=> flags[4:0] == 5'h00;
  endproperty
  a_ovf_read_clear: assert property (p_ovf_read_clear) else $error("overflow flags not cleared"); // R14

  property p_pwr_read;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_rd && i_reg_addr == `OFS_PLAYBACK_POWER_STATUS) |=>
        {o_reg_rdata[7], o_reg_rdata[5:3], o_reg_rdata[1:0]} == $past(play_power_s) &&
        o_reg_rdata[6] == 1'b0 && o_reg_rdata[2] == 1'b0;
  endproperty
  a_pwr_read: assert property (p_pwr_read) else $error("playback power status wrong"); // R12

  property p_gain_read;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_rd && i_reg_addr == `OFS_PLAYBACK_GAIN_STATUS) |=>
        o_reg_rdata[4] == $past(left_gain_ok_s) && o_reg_rdata[0] == $past(right_gain_ok_s) &&
        o_reg_rdata[7:5] == 3'h0 && o_reg_rdata[3:1] == 3'h0;
  endproperty
  a_gain_read: assert property (p_gain_read) else $error("playback gain status wrong"); // R13

  property p_agc_sat_set;
    @(posedge i_clk) disable iff (i_sys_rst)
      ev_pulse[5] |=> flags[5];
  endproperty
  a_agc_sat_set: assert property (p_agc_sat_set) else $error("saturation flag not set"); // R10
endmodule

// *** audio_port_peer.sv ***
/*
  far-side peer on the serial audio ports: drives the primary and secondary
  bit clock, word clock and data inputs of the routing block.
  assumes: runs on the link clock; frames are opened by i_frame.
*/
`timescale 1ns/1ps
module audio_port_peer (
  input wire logic i_link_clk,
  input wire logic i_frame,
  output logic o_pri_bclk,
  output logic o_pri_wclk,
  output logic o_pri_din,
  output logic o_sec_bclk,
  output logic o_sec_wclk,
  output logic o_sec_din
);
  logic [3:0] cnt_q;
  logic [7:0] lfsr_q;
  initial begin
    cnt_q = 4'h0;
    lfsr_q = 8'hA5;
    {o_pri_bclk, o_pri_wclk, o_pri_din, o_sec_bclk, o_sec_wclk, o_sec_din} = 6'h00;
  end
  // clocks stand still between frames; released data flips so a stale bit never matches by luck
  always @(posedge i_link_clk) begin
    if (i_frame) begin
      cnt_q <= cnt_q + 4'h1;
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      o_pri_bclk <= cnt_q[0];
      o_sec_bclk <= ~cnt_q[0];
      o_pri_wclk <= cnt_q[3];
      o_sec_wclk <= cnt_q[2];
      o_pri_din <= lfsr_q[0];
      o_sec_din <= lfsr_q[1];
    end else begin
      o_pri_din <= ~o_pri_din;
      o_sec_din <= ~o_sec_din;
    end
  end
endmodule

// *** tb_audio_route_regs.sv ***
/*
  self-checking bench of the routing and status register slice.
  assumes: the peer model drives the port inputs; reads are checked by a
  monitor that pops expected notes from a queue.
*/
`timescale 1ns/1ps
`include "audio_route_consts.svh"
module tb_audio_route_regs;
  import audio_route_pkg::*;
  typedef struct {reg_byte_t e; reg_byte_t m;} note_t;
  note_t q[$];
  logic i_clk = 0, i_sys_rst = 1, i_link_clk = 0, i_link_rst = 1, i_reg_wr = 0, i_reg_rd = 0;
  logic [7:0] i_reg_addr = 8'h00, route;
  reg_byte_t i_reg_wdata = 8'h00, o_reg_rdata, v, v1, bm;
  logic o_general_call_en, i_int_bclk = 0, i_play_rate_clk = 0, i_rec_rate_clk = 0, i_iface_dout = 0;
  logic i_pri_bclk, i_pri_wclk, i_pri_din, i_sec_bclk, i_sec_wclk, i_sec_din, frame = 0, taken = 0;
  logic o_pri_bclk, o_pri_wclk, o_pri_dout, o_sec_bclk, o_sec_wclk, o_sec_dout;
  logic i_rec_gain_ok = 0, i_rec_powered = 0, i_left_gain_ok = 0, i_right_gain_ok = 0;
  logic [5:0] i_play_power = 6'h00, i_event_tgl = 6'h00;
  logic [7:0] addrs [10] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2B, 8'h50};
  int ev_pos [6] = '{`POS_OVF_REC_SHIFT, `POS_OVF_REC_CONV, `POS_OVF_PLAY_SHIFT, `POS_OVF_RIGHT_PLAY,
    `POS_OVF_LEFT_PLAY, `POS_AGC_SAT};
  int seed = 79308, err_total = 0, n_compared = 0;
  initial begin
    forever #4 i_clk = ~i_clk;
  end
  // link clock phase offset keeps its edges off every bench sampling instant
  initial begin
    #7.3;
    forever #15 i_link_clk = ~i_link_clk;
  end
  audio_route_regs DUT (.i_clk, .i_sys_rst, .i_link_clk, .i_link_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .o_general_call_en, .i_int_bclk, .i_play_rate_clk, .i_rec_rate_clk,
    .i_iface_dout, .i_pri_bclk, .i_pri_wclk, .i_pri_din, .i_sec_bclk, .i_sec_wclk, .i_sec_din, .o_pri_bclk,
    .o_pri_wclk, .o_pri_dout, .o_sec_bclk, .o_sec_wclk, .o_sec_dout, .i_rec_gain_ok, .i_rec_powered,
    .i_play_power, .i_left_gain_ok, .i_right_gain_ok, .i_event_tgl);
  audio_port_peer peer (.i_link_clk, .i_frame(frame), .o_pri_bclk(i_pri_bclk), .o_pri_wclk(i_pri_wclk),
    .o_pri_din(i_pri_din), .o_sec_bclk(i_sec_bclk), .o_sec_wclk(i_sec_wclk), .o_sec_din(i_sec_din));
  always @(negedge i_clk) begin
    {i_int_bclk, i_play_rate_clk, i_rec_rate_clk, i_iface_dout} <= 4'($random(seed));
  end
  task automatic chk(input reg_byte_t got, input reg_byte_t exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input reg_byte_t d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(negedge i_clk);
    i_reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input reg_byte_t e, input reg_byte_t m);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd = 1;
    q.push_back('{e, m});
    @(negedge i_clk);
    i_reg_rd = 0;
    v = o_reg_rdata;
  endtask
  // read data is looked at on the falling edge half a cycle after the rising edge that took the strobe
  always @(posedge i_clk) taken <= i_reg_rd;
  always @(negedge i_clk) begin
    note_t n;
    if (taken === 1'b1 && q.size() > 0) begin
      n = q.pop_front();
      chk(o_reg_rdata & n.m, n.e & n.m);
    end
  end
  function automatic logic [5:0] mux_exp(input logic [7:0] r);
    logic p, s;
    p = r[5:4] == 2'h0 ? i_play_rate_clk : r[5:4] == 2'h1 ? i_rec_rate_clk : r[5:4] == 2'h2 ? i_sec_wclk : 1'b0;
    s = r[3:2] == 2'h0 ? i_pri_wclk : r[3:2] == 2'h1 ? i_play_rate_clk : r[3:2] == 2'h2 ? i_rec_rate_clk : 1'b0;
    return {r[7] ? i_sec_bclk : i_int_bclk, r[6] ? i_int_bclk : i_pri_bclk, p, s,
      r[1] ? i_sec_din : i_iface_dout, r[0] ? i_iface_dout : i_pri_din};
  endfunction
  initial begin
    #400000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (10) @(negedge i_clk);
    i_sys_rst = 0;
    i_link_rst = 0;
    foreach (addrs[i]) rd(addrs[i], 8'h00, 8'hFF);
    wr(`OFS_BUS_GENERAL_CALL_CTRL, 8'h20);
    chk({7'h00, o_general_call_en}, 8'h01);
    rd(`OFS_BUS_GENERAL_CALL_CTRL, 8'h20, 8'hFF);
    wr(`OFS_BUS_GENERAL_CALL_CTRL, 8'h00);
    chk({7'h00, o_general_call_en}, 8'h00);
    for (int i = 0; i < 16; i++) begin
      bm = 8'($random(seed));
      route = {bm[7:6], 2'(i), 2'(i >> 2), bm[1:0]};
      frame = ~i[0];
      wr(`OFS_AUDIO_PORT_ROUTING, route);
      cyc(16);
      rd(`OFS_AUDIO_PORT_ROUTING, route, 8'hFF);
      repeat (6) begin
        cyc(1);
        chk({2'h0, o_pri_bclk, o_sec_bclk, o_pri_wclk, o_sec_wclk, o_pri_dout, o_sec_dout},
          {2'h0, mux_exp(route)});
      end
    end
    repeat (8) begin
      {i_rec_gain_ok, i_rec_powered, i_left_gain_ok, i_right_gain_ok, i_play_power} = 10'($random(seed));
      cyc(4);
      rd(`OFS_RECORD_STATUS, {i_rec_gain_ok, i_rec_powered, 6'h00}, 8'hC0);
      rd(`OFS_PLAYBACK_POWER_STATUS, {i_play_power[5], 1'b0, i_play_power[4:2], 1'b0, i_play_power[1:0]},
        8'hBB);
      rd(`OFS_PLAYBACK_GAIN_STATUS, {3'h0, i_left_gain_ok, 3'h0, i_right_gain_ok}, 8'h11);
    end
    for (int k = 0; k < 6; k++) begin
      route = k == 5 ? `OFS_RECORD_STATUS : `OFS_OVERFLOW_STATUS;
      bm = 8'h01 << ev_pos[k];
      i_event_tgl[k] = ~i_event_tgl[k];
      cyc(5);
      wr(route, 8'h00);
      rd(route, bm, bm);
      rd(route, 8'h00, bm);
    end
    for (int d = 0; d < 5; d++) begin
      i_event_tgl[4] = ~i_event_tgl[4];
      cyc(d);
      rd(`OFS_OVERFLOW_STATUS, d >= 2 ? 8'h80 : 8'h00, 8'h80);
      v1 = v;
      cyc(5);
      rd(`OFS_OVERFLOW_STATUS, d >= 2 ? 8'h00 : 8'h80, 8'h80);
      chk({7'h00, v1[7] ^ v[7]}, 8'h01);
    end
    final_report();
  end
endmodule
